// ===== design/mgmt_status_defs.svh
// Constants for the module management status and timing block.
`ifndef MGMT_STATUS_DEFS_SVH
`define MGMT_STATUS_DEFS_SVH

// Clock and timing figures.
`define CLK_PERIOD_NS 5
`define T_RESET_MIN_NS 2000
`define RESET_MIN_CYCLES \
  ((`T_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_INIT_MS 2000
`define INIT_CYCLES (`T_INIT_MS * 1000000 / `CLK_PERIOD_NS)

// Register byte offsets.
`define REG_STATUS_OFF 32'h0000_0000
`define REG_FLAGS_OFF 32'h0000_0004
`define REG_MASK_OFF 32'h0000_0008
`define REG_CTRL_OFF 32'h0000_000C

// Status register fields.
`define ST_NOT_READY_BIT 0
`define ST_BUS_RESPOND_BIT 1
`define ST_LOW_POWER_BIT 2
`define ST_ATTN_ACTIVE_BIT 3
`define ST_LP_PIN_BIT 4
`define ST_ATTN_PIN_BIT 5

// Flag register fields.
`define NUM_COND 8
`define FLAG_RX_LOS_BIT 0
`define FLAG_TX_FAULT_BIT 1
`define FLAG_INIT_DONE_BIT 8
`define FLAG_W 9

// Control register field, mask reset value and bus transfer encodings.
`define CTRL_PDOWN_BIT 0
`define MASK_RESET 9'h000
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2

`endif

// ===== design/mgmt_status_pkg.sv
// Types shared by the module management status and timing block.
package mgmt_status_pkg;

  typedef struct packed {
    logic resetN;
    logic lpReq;
    logic selN;
    logic scl;
    logic sda;
    logic attn;
  } pin_s;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_INIT,
    ST_READY
  } init_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic valid;
  } ahb_req_s;

endpackage : mgmt_status_pkg

// ===== design/module_mgmt_status_timing.sv
// Management-side reset, readiness, attention and power sequencing.
//
// Summary of operation
// - A reset pin low longer than 2 us resets the module.
// - The 2-wire bus is served within 2000 ms of power on.
// - Within 2000 ms of power on clear not-ready and raise attention.
// - After reset pin rises, full function comes within 2000 ms.
// - Attention raised by the not-ready clear marks end of initialization.
// - Low power request high enters low power within 100 us.
// - Any attention condition drives attention low within 200 ms.
// - Flags clear on read; attention released within 500 us after.
// - Receive signal loss sets its flag and attention within 100 ms.
// - Transmit fault sets its flag and attention within 200 ms.
// - Any other condition sets its flag and attention within 200 ms.
// - Setting a mask bit stops attention for its flag within 100 ms.
// - Clearing a mask bit resumes attention for its flag within 100 ms.
// - Bus is served within 100 us after module select goes low.
// - Bus service stops within 100 us after module select goes high.
// - Setting power-down override enters low power within 100 ms.
// - Clearing power-down override restores full function within 300 ms.
// - Clear-on-read intervals count from falling clock after read stop.
// - Mask and power-down intervals count from falling clock after stop.
// - Power on or reset rise completes initialization within 2000 ms.
`timescale 1ns/1ps
`include "mgmt_status_defs.svh"

module module_mgmt_status_timing #(
  parameter int INIT_DELAY_CYCLES = `INIT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Module pins
  input wire logic module_reset_n,
  input wire logic low_power_request,
  input wire logic module_select_n,
  input wire logic serialClockPin,
  input wire logic serialDataPin,
  input wire logic attentionIn,
  output logic attention_out_n,
  output logic attentionOe,
  // Device side
  input wire logic [`NUM_COND-1:0] conditionIn,
  output logic busRespondEnable,
  output logic lowPowerMode,
  output logic dataNotReady
);

  localparam int PINS = $bits(mgmt_status_pkg::pin_s);
  localparam int RESET_MIN = `RESET_MIN_CYCLES;

  function automatic logic isReg(input logic [31:0] addr,
                                 input logic [31:0] off);
    isReg = (addr == off);
  endfunction : isReg

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  mgmt_status_pkg::pin_s pinRaw;
  mgmt_status_pkg::pin_s pinQ;
  logic [PINS-1:0] sync1Q;
  logic [PINS-1:0] sync2Q;
  logic [PINS-1:0] sync3Q;
  logic [PINS-1:0] pinFiltQ;

  assign pinRaw = '{resetN: module_reset_n, lpReq: low_power_request,
                    selN: module_select_n, scl: serialClockPin,
                    sda: serialDataPin, attn: attentionIn};
  assign pinQ = mgmt_status_pkg::pin_s'(pinFiltQ);

  // Each stage starts at its pin's idle level, so no false edge follows reset.
  localparam mgmt_status_pkg::pin_s PIN_IDLE = '{resetN: 1'b1,
    lpReq: 1'b0, selN: 1'b1, scl: 1'b1, sda: 1'b1, attn: 1'b1};

  // Each pin counts as changed once the second and third stage agree.
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++)
    begin : g_sync
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          sync1Q[gi] <= PIN_IDLE[gi];
          sync2Q[gi] <= PIN_IDLE[gi];
          sync3Q[gi] <= PIN_IDLE[gi];
          pinFiltQ[gi] <= PIN_IDLE[gi];
        end
        else
        begin
          sync1Q[gi] <= pinRaw[gi];
          sync2Q[gi] <= sync1Q[gi];
          sync3Q[gi] <= sync2Q[gi];
          if (sync2Q[gi] == sync3Q[gi])
          begin
            pinFiltQ[gi] <= sync3Q[gi];
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Serial bus frame end: first falling clock edge after a stop.

  logic sclPrevQ;
  logic sdaPrevQ;
  logic stopSeenQ;
  logic frameEnd;

  assign frameEnd = stopSeenQ && sclPrevQ && !pinQ.scl;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sclPrevQ <= 1'b1;
      sdaPrevQ <= 1'b1;
      stopSeenQ <= 1'b0;
    end
    else
    begin
      sclPrevQ <= pinQ.scl;
      sdaPrevQ <= pinQ.sda;
      if (frameEnd)
      begin
        stopSeenQ <= 1'b0;
      end
      else if (pinQ.scl && sclPrevQ && pinQ.sda && !sdaPrevQ)
      begin
        stopSeenQ <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Reset pulse qualification and initialization sequence.

  mgmt_status_pkg::init_state_e initState_q;
  logic [31:0] initCnt_q;
  logic [15:0] lowCnt_q;
  logic initDone;

  assign initDone = (initState_q == mgmt_status_pkg::ST_INIT) &&
                    (initCnt_q >= 32'(INIT_DELAY_CYCLES - 1));

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      lowCnt_q <= 16'h0000;
    end
    else if (pinQ.resetN)
    begin
      lowCnt_q <= 16'h0000;
    end
    else if (lowCnt_q < 16'(RESET_MIN))
    begin
      lowCnt_q <= lowCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      initState_q <= mgmt_status_pkg::ST_INIT;
      initCnt_q <= 32'h0000_0000;
    end
    else if (!pinQ.resetN && lowCnt_q >= 16'(RESET_MIN))
    begin
      initState_q <= mgmt_status_pkg::ST_HOLD;
      initCnt_q <= 32'h0000_0000;
    end
    else
    begin
      unique case (initState_q)
        mgmt_status_pkg::ST_HOLD:
        begin
          if (pinQ.resetN)
          begin
            initState_q <= mgmt_status_pkg::ST_INIT;
          end
        end
        mgmt_status_pkg::ST_INIT:
        begin
          if (initDone)
          begin
            initState_q <= mgmt_status_pkg::ST_READY;
          end
          else
          begin
            initCnt_q <= initCnt_q + 32'h0000_0001;
          end
        end
        mgmt_status_pkg::ST_READY:
        begin
          initCnt_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY.

  mgmt_status_pkg::ahb_req_s req_q;
  logic addrPhase;
  logic [`FLAG_W-1:0] flags_q;
  logic [`FLAG_W-1:0] clearPend_q;
  logic [`FLAG_W-1:0] maskShadow_q;
  logic [`FLAG_W-1:0] maskActive_q;
  logic pdownShadow_q;
  logic pdownActive_q;
  logic [31:0] status;
  logic resetActive;
  logic readFlags;
  logic wrMask;
  logic wrCtrl;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel && hready && (htrans == `HTRANS_NONSEQ) &&
                     (hsize == `HSIZE_WORD);
  assign readFlags = addrPhase && !hwrite && isReg(haddr, `REG_FLAGS_OFF);
  assign wrMask = req_q.valid && req_q.write &&
                  isReg(req_q.addr, `REG_MASK_OFF);
  assign wrCtrl = req_q.valid && req_q.write &&
                  isReg(req_q.addr, `REG_CTRL_OFF);
  assign resetActive = (initState_q == mgmt_status_pkg::ST_HOLD);

  always_comb
  begin
    status = 32'h0000_0000;
    status[`ST_NOT_READY_BIT] = dataNotReady;
    status[`ST_BUS_RESPOND_BIT] = busRespondEnable;
    status[`ST_LOW_POWER_BIT] = lowPowerMode;
    status[`ST_ATTN_ACTIVE_BIT] = attentionOe;
    status[`ST_LP_PIN_BIT] = pinQ.lpReq;
    status[`ST_ATTN_PIN_BIT] = pinQ.attn;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      req_q <= '0;
    end
    else if (hready)
    begin
      req_q <= '{addr: haddr, write: hwrite, valid: addrPhase};
    end
  end

  // Read data is captured in the address phase so it stands in the data
  // phase straight from flip-flops.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (addrPhase && !hwrite)
    begin
      if (isReg(haddr, `REG_STATUS_OFF))
      begin
        hrdata <= status;
      end
      else if (isReg(haddr, `REG_FLAGS_OFF))
      begin
        hrdata <= 32'(flags_q);
      end
      else if (isReg(haddr, `REG_MASK_OFF))
      begin
        hrdata <= 32'(maskShadow_q);
      end
      else if (isReg(haddr, `REG_CTRL_OFF))
      begin
        hrdata <= 32'(pdownShadow_q);
      end
      else
      begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flags, masks and power-down override.

  logic [`NUM_COND-1:0] condPrev_q;
  logic [`FLAG_W-1:0] flagSet;

  // Entering a condition sets its flag; the end of init sets its own.
  always_comb
  begin
    flagSet = '0;
    flagSet[`NUM_COND-1:0] = conditionIn & ~condPrev_q;
    flagSet[`FLAG_INIT_DONE_BIT] = initDone;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || resetActive)
    begin
      condPrev_q <= '0;
      flags_q <= '0;
      clearPend_q <= '0;
    end
    else
    begin
      condPrev_q <= conditionIn;
      // A set in the same cycle as a clear wins over the clear.
      if (frameEnd)
      begin
        flags_q <= (flags_q & ~clearPend_q) | flagSet;
        clearPend_q <= readFlags ? flags_q : '0;
      end
      else
      begin
        flags_q <= flags_q | flagSet;
        if (readFlags)
        begin
          clearPend_q <= clearPend_q | flags_q;
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || resetActive)
    begin
      maskShadow_q <= `MASK_RESET;
      maskActive_q <= `MASK_RESET;
      pdownShadow_q <= 1'b0;
      pdownActive_q <= 1'b0;
    end
    else
    begin
      if (wrMask)
      begin
        maskShadow_q <= hwdata[`FLAG_W-1:0];
      end
      if (wrCtrl)
      begin
        pdownShadow_q <= hwdata[`CTRL_PDOWN_BIT];
      end
      if (frameEnd)
      begin
        maskActive_q <= maskShadow_q;
        pdownActive_q <= pdownShadow_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output drive.

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      attention_out_n <= 1'b1;
      attentionOe <= 1'b0;
      busRespondEnable <= 1'b0;
      lowPowerMode <= 1'b0;
      dataNotReady <= 1'b1;
    end
    else
    begin
      // Open drain: drive low only while an unmasked flag is set.
      attention_out_n <= ~|(flags_q & ~maskActive_q);
      attentionOe <= |(flags_q & ~maskActive_q);
      busRespondEnable <= !pinQ.selN && !resetActive &&
                          (initState_q == mgmt_status_pkg::ST_READY) ||
                          (initDone && !pinQ.selN);
      lowPowerMode <= pinQ.lpReq || pdownActive_q;
      dataNotReady <= (initState_q != mgmt_status_pkg::ST_READY) &&
                      !initDone;
    end
  end

endmodule : module_mgmt_status_timing

// ===== sim/mgmt_status_sva.sv
// Assertion checker for the management status block.
`timescale 1ns/1ps
`include "mgmt_status_defs.svh"

module mgmt_status_sva #(
  parameter int INIT_DELAY_CYCLES = 50
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  // Pins
  input wire logic low_power_request,
  input wire logic module_select_n,
  input wire logic serialClockPin,
  input wire logic attention_out_n,
  input wire logic attentionOe,
  // Device side
  input wire logic [`NUM_COND-1:0] conditionIn,
  input wire logic busRespondEnable,
  input wire logic lowPowerMode,
  input wire logic dataNotReady
);
  localparam int NR_MAX = INIT_DELAY_CYCLES + `RESET_MIN_CYCLES + 64;
  logic maskZero_q;
  logic [1:0] sclSync_q;
  logic [7:0] fallAge_q;
  int nrCnt_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Any write towards the mask register retires the mask-free checks.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      maskZero_q <= 1'b1;
    else if (hsel && htrans == `HTRANS_NONSEQ && hwrite
             && haddr == `REG_MASK_OFF)
      maskZero_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    sclSync_q <= {sclSync_q[0], serialClockPin};
    if (sys_rst || sclSync_q == 2'b10)
      fallAge_q <= 8'h00;
    else if (fallAge_q != 8'hFF)
      fallAge_q <= fallAge_q + 8'h01;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || !dataNotReady)
      nrCnt_q <= 0;
    else
      nrCnt_q <= nrCnt_q + 1;
  end

  AST_OE_PAIR: assert property (
    attentionOe == !attention_out_n) else $error("enable and pin differ");
  AST_RESET_OUT: assert property (
    $fell(sys_rst) |-> attention_out_n && !busRespondEnable
      && !lowPowerMode && dataNotReady) else $error("bad reset outputs");
  AST_INIT_BOUND: assert property (
    nrCnt_q <= NR_MAX) else $error("not ready too long");
  AST_READY_ATTN: assert property (
    $fell(dataNotReady) && maskZero_q |-> ##[0:2] !attention_out_n)
    else $error("no attention at ready");
  AST_FLAG_ATTN: assert property (
    maskZero_q && !dataNotReady && (|(conditionIn & ~$past(conditionIn)))
      |-> ##[1:2] !attention_out_n) else $error("no attention on flag");
  AST_LP_PIN: assert property (
    $rose(low_power_request) |-> ##[1:8] lowPowerMode)
    else $error("low power late");
  AST_SEL_ON: assert property (
    $fell(module_select_n) && !dataNotReady |-> ##[1:8] busRespondEnable)
    else $error("select ignored");
  AST_SEL_OFF: assert property (
    $rose(module_select_n) |-> ##[1:8] !busRespondEnable)
    else $error("deselect ignored");
  AST_BUS_READY: assert property (
    dataNotReady [*2] |-> !busRespondEnable) else $error("bus early");
  AST_RELEASE_FRAME: assert property (
    $rose(attention_out_n) && !dataNotReady && !$past(dataNotReady)
      |-> fallAge_q < 8'd12) else $error("release off frame end");

  COV_FLAG: cover property ($rose(attentionOe));
  COV_READY: cover property ($fell(dataNotReady));
  COV_LOW: cover property ($rose(lowPowerMode));
endmodule : mgmt_status_sva

bind module_mgmt_status_timing mgmt_status_sva #(
  .INIT_DELAY_CYCLES(INIT_DELAY_CYCLES)
) mgmt_status_sva_inst (
  .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite),
  .low_power_request(low_power_request),
  .module_select_n(module_select_n), .serialClockPin(serialClockPin),
  .attention_out_n(attention_out_n), .attentionOe(attentionOe),
  .conditionIn(conditionIn), .busRespondEnable(busRespondEnable),
  .lowPowerMode(lowPowerMode), .dataNotReady(dataNotReady)
);

// ===== sim/host_link_model.sv
// Host model that clocks one 2-wire frame per request.
`timescale 1ns/1ps

module host_link_model #(
  parameter int HALF_NS = 24
) (
  // Request
  input wire logic req,
  // Lines, pulled up while released
  output logic scl,
  output logic sda,
  output logic busy
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    busy = 1'b0;
  end

  // The clock stands high between frames.
  always @(posedge req)
  begin
    busy = 1'b1;
    #HALF_NS sda = 1'b0;
    #HALF_NS scl = 1'b0;
    repeat (4)
    begin
      #HALF_NS sda = ~sda;
      #HALF_NS scl = 1'b1;
      #HALF_NS scl = 1'b0;
    end
    #HALF_NS sda = 1'b0;
    #HALF_NS scl = 1'b1;
    #HALF_NS sda = 1'b1;
    #HALF_NS scl = 1'b0;
    #HALF_NS scl = 1'b1;
    busy = 1'b0;
  end
endmodule : host_link_model

// ===== sim/test_module_mgmt_status_timing.sv
// Self-checking bench for the management status block.
`timescale 1ns/1ps
`include "mgmt_status_defs.svh"

module test_module_mgmt_status_timing;
  localparam int INIT = 50;
  localparam int W_RDY = 0;
  localparam int W_BUSY = 1;
  logic [2:0] hsize = `HSIZE_WORD;
  logic clock = 0;
  logic sys_rst = 1;
  logic hsel = 0;
  logic hwrite = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic hreadyout, hresp, attention_out_n, attentionOe;
  logic resetN = 1, lpReq = 0, selN = 1, req = 0, scl, sda, busy;
  logic [7:0] cond = 0, pat;
  logic busRespondEnable, lowPowerMode, dataNotReady;
  int err_count = 0, cmp_count = 0;

  always #2.5 clock = ~clock;

  module_mgmt_status_timing #(
    .INIT_DELAY_CYCLES(INIT)
  ) module_mgmt_status_timing_inst (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .module_reset_n(resetN),
    .low_power_request(lpReq), .module_select_n(selN),
    .serialClockPin(scl), .serialDataPin(sda), .attentionIn(~attentionOe),
    .attention_out_n(attention_out_n), .attentionOe(attentionOe),
    .conditionIn(cond), .busRespondEnable(busRespondEnable),
    .lowPowerMode(lowPowerMode), .dataNotReady(dataNotReady)
  );

  host_link_model host_link_model_inst (
    .req(req), .scl(scl), .sda(sda), .busy(busy)
  );

  function automatic logic attnExp(logic [8:0] f, logic [8:0] m);
    return !(|(f & ~m));
  endfunction : attnExp

  task automatic final_report;
    $display("errors %0d checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // Selects the watched signal; anything else means the not-ready output.
  function automatic logic pick(input int which);
    if (which == W_RDY)
      return hreadyout;
    else if (which == W_BUSY)
      return busy;
    return dataNotReady;
  endfunction : pick

  task automatic waitLvl(input int which, input logic v);
    for (int n = 0; n < 2000; n++)
    begin
      @(posedge clock);
      if (pick(which) === v)
        return;
    end
    chk(pick(which), v);
    final_report();
  endtask : waitLvl

  task automatic ahb(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= `HTRANS_NONSEQ;
    waitLvl(W_RDY, 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    waitLvl(W_RDY, 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask : ahb

  task automatic frame;
    req <= 1'b1;
    waitLvl(W_BUSY, 1'b1);
    req <= 1'b0;
    waitLvl(W_BUSY, 1'b0);
    tick(8);
  endtask : frame

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h3415));
    tick(10);
    sys_rst <= 1'b0;
    waitLvl(2, 1'b0);
    tick(3);
    chk(attention_out_n, attnExp(9'h100, 9'h000));
    ahb(0, `REG_STATUS_OFF, 0);
    chk(rd[4:0], 5'h08);
    ahb(0, `REG_FLAGS_OFF, 0);
    chk(rd[8:0], 9'h100);
    tick(20);
    chk(attention_out_n, 0);
    frame();
    chk(attention_out_n, 1);
    selN <= 1'b0;
    tick(8);
    chk(busRespondEnable, 1);
    selN <= 1'b1;
    tick(8);
    chk(busRespondEnable, 0);
    // Each condition alone, then a random mix.
    for (int k = 0; k < 9; k++)
    begin
      pat = (k < 8) ? 8'h01 << k : 8'($urandom) | 8'h01;
      cond <= pat;
      tick(3);
      chk(attention_out_n, attnExp({1'b0, pat}, 0));
      ahb(0, `REG_FLAGS_OFF, 0);
      chk(rd[8:0], {1'b0, pat});
      cond <= 8'h00;
      frame();
      chk(attention_out_n, 1);
    end
    ahb(0, `REG_FLAGS_OFF, 0);
    chk(rd, 0);
    lpReq <= 1'b1;
    tick(8);
    chk(lowPowerMode, 1);
    lpReq <= 1'b0;
    ahb(1, `REG_CTRL_OFF, 1);
    tick(8);
    chk(lowPowerMode, 0);
    frame();
    chk(lowPowerMode, 1);
    ahb(1, `REG_CTRL_OFF, 0);
    frame();
    chk(lowPowerMode, 0);
    ahb(1, `REG_MASK_OFF, 1);
    ahb(0, `REG_MASK_OFF, 0);
    chk(rd, 1);
    frame();
    cond <= 8'h01;
    tick(3);
    chk(attention_out_n, attnExp(9'h001, 9'h001));
    ahb(1, `REG_MASK_OFF, 0);
    frame();
    chk(attention_out_n, 0);
    ahb(0, `REG_FLAGS_OFF, 0);
    cond <= 8'h00;
    frame();
    chk(attention_out_n, 1);
    ahb(0, 32'h0000_0010, 0);
    chk(rd, 0);
    // A byte-sized write must be ignored.
    hsize <= 3'h0;
    ahb(1, `REG_MASK_OFF, 32'h0000_01FF);
    hsize <= `HSIZE_WORD;
    ahb(0, `REG_MASK_OFF, 0);
    chk(rd, 0);
    // A short reset pulse is ignored, a long one restarts init.
    resetN <= 1'b0;
    tick(50);
    resetN <= 1'b1;
    tick(8);
    chk(dataNotReady, 0);
    resetN <= 1'b0;
    tick(`RESET_MIN_CYCLES + 20);
    chk(dataNotReady, 1);
    resetN <= 1'b1;
    waitLvl(2, 1'b0);
    tick(3);
    chk(attention_out_n, 0);
    final_report();
  end
endmodule : test_module_mgmt_status_timing
